/* bridge_fault_pkg.sv */
/*
  Constants for the bridge fault supervisor: filter times, cycle counts,
  status bit positions and reset values of the configuration bits.
  Assumes a 50 MHz system clock.
*/
`default_nettype none
package bridge_fault_pkg;
  // ----------------------------------------------------------------
  // Clock and filter times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;      // System clock rate
  localparam int UV_FILTER_US   = 10;      // Undervoltage filter, shorter than OT
  localparam int OV_FILTER_NS   = 3000;    // Overvoltage filter, 3.0 us
  localparam int OT_FILTER_US   = 11;      // Overtemperature filter
  localparam int TW_CYCLES      = 2;       // Warning deglitch only, flag is live
  localparam int UV_CYCLES      = UV_FILTER_US * CLK_MHZ;          // Rounded down
  localparam int OV_CYCLES      = (OV_FILTER_NS * CLK_MHZ) / 1000; // Rounded down
  localparam int OT_CYCLES      = OT_FILTER_US * CLK_MHZ;          // Rounded down
  localparam int CNT_W          = 10;      // Counter width, holds 550

  // ----------------------------------------------------------------
  // Status and mask bit positions
  // ----------------------------------------------------------------
  localparam int ST_OT   = 0;
  localparam int ST_TW   = 1;
  localparam int ST_SCG1 = 4;
  localparam int ST_SCG2 = 5;
  localparam int ST_SCP1 = 6;
  localparam int ST_SCP2 = 7;
  localparam int ST_OV   = 8;
  localparam int ST_UV   = 9;
  localparam int ST_W    = 10;             // Status vector width

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] MASK_RESET = 10'h2F1; // UV, SC*, OT set; OV, TW clear
  localparam logic       OVD_RESET  = 1'b0;    // Overvoltage protection active

  // Output drive commands of one bridge leg
  typedef enum logic [1:0] {LEG_OFF, LEG_HIGH, LEG_LOW} leg_cmd_t;
endpackage : bridge_fault_pkg
`default_nettype wire

/* fault_filter_if.sv */
/*
  Interface carrying one filtered comparator between the supervisor and
  its filter instance. Assumes one clock, driven by the supervisor.
*/
`timescale 1ns/1ps
`default_nettype none
interface fault_filter_if;
  logic rawLevel;    // Unsynchronised comparator level
  logic filtered;    // Level after synchroniser and filter
  modport sup (output rawLevel, input filtered);
  modport flt (input rawLevel, output filtered);
endinterface : fault_filter_if
`default_nettype wire

/* deglitch_filter.sv */
/*
  Two-stage synchroniser plus symmetric time filter for one comparator.
  The output changes only after the synced input differs from it for
  LIMIT consecutive cycles. Assumes a synchronous, active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module deglitch_filter #(
  parameter int LIMIT = 4
) (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  fault_filter_if.flt    port
);
  import bridge_fault_pkg::*;

  // ----------------------------------------------------------------
  // Synchroniser and counter
  // ----------------------------------------------------------------
  logic             syncA_reg;   // First stage, read only by second
  logic             syncB_reg;   // Second stage
  logic             out_reg;     // Filtered level
  logic [CNT_W-1:0] cnt_reg;     // Cycles of disagreement

  wire differ  = syncB_reg != out_reg;                  // Input disagrees
  wire expired = cnt_reg == CNT_W'(LIMIT - 1);          // Time reached

  // Counter restarts whenever input falls back before expiry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      out_reg   <= 1'b0;
      cnt_reg   <= '0;
    end else begin
      syncA_reg <= port.rawLevel;
      syncB_reg <= syncA_reg;
      if (!differ) begin
        cnt_reg <= '0;
      end else if (expired) begin
        out_reg <= syncB_reg;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign port.filtered = out_reg;

  // Output may only change after LIMIT disagreeing cycles
  property p_filter_hold;
    @(posedge clk) disable iff (sys_rst)
      $changed(out_reg) |-> ($past(cnt_reg) == CNT_W'(LIMIT - 1));
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filter output moved before its count expired");
endmodule : deglitch_filter
`default_nettype wire

/* bridge_fault_supervisor.sv */
/*
  Protection and supervision for a two-leg bridge driver: filters supply
  and temperature comparators, decodes pins into leg commands, latches
  faults and drives the active-low fault status pin.
  Assumes comparator and short inputs are raw levels, pins synchronous,
  and a host that pulses faultClear to clear latched flags.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_fault_supervisor (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       chip_enable_pin,     // Low or floating: sleep
  input  wire logic                       disable_pin,         // High or floating: off
  input  wire logic                       direction_input_one, // Floating reads low
  input  wire logic                       direction_input_two,
  input  wire logic                       virtual_input_one,
  input  wire logic                       virtual_input_two,
  input  wire logic                       inputSelect,         // 1: virtual inputs
  input  wire logic                       outputEnable,        // Output-enable bit
  input  wire logic                       bridgeMode,          // 1: full bridge
  input  wire logic                       ov_protect_disable,
  input  wire logic [9:0]                 faultMask,           // Status bit order
  input  wire logic                       faultClear,          // One-cycle clear pulse
  input  wire logic                       uvComp,              // Supply below threshold
  input  wire logic                       ovComp,              // Supply above threshold
  input  wire logic                       twComp,              // Temp above warning
  input  wire logic                       otComp,              // Temp above shutdown
  input  wire logic [3:0]                 shortDetect,         // SCG1,SCG2,SCP1,SCP2
  output logic [1:0]                      highSideOn,          // [0] leg one
  output logic [1:0]                      lowSideOn,
  output logic                            fault_status_n,
  output logic [bridge_fault_pkg::ST_W-1:0] statusFlags
);
  import bridge_fault_pkg::*;

  // ----------------------------------------------------------------
  // Comparator filters
  // ----------------------------------------------------------------
  fault_filter_if uvIf ();   // Undervoltage path
  fault_filter_if ovIf ();   // Overvoltage path
  fault_filter_if otIf ();   // Overtemperature path
  fault_filter_if twIf ();   // Warning path, short filter only

  assign uvIf.rawLevel = uvComp;
  assign ovIf.rawLevel = ovComp;
  assign otIf.rawLevel = otComp;
  assign twIf.rawLevel = twComp;

  // Symmetric filter on undervoltage gives both entry and recovery times
  deglitch_filter #(.LIMIT(UV_CYCLES)) uUv (.clk(clk), .sys_rst(sys_rst), .port(uvIf));
  deglitch_filter #(.LIMIT(OV_CYCLES)) uOv (.clk(clk), .sys_rst(sys_rst), .port(ovIf));
  deglitch_filter #(.LIMIT(OT_CYCLES)) uOt (.clk(clk), .sys_rst(sys_rst), .port(otIf));
  deglitch_filter #(.LIMIT(TW_CYCLES)) uTw (.clk(clk), .sys_rst(sys_rst), .port(twIf));

  wire uvActive = uvIf.filtered;   // Live undervoltage condition
  wire ovActive = ovIf.filtered;   // Live overvoltage condition
  wire otActive = otIf.filtered;   // Live overtemperature
  wire twActive = twIf.filtered;   // Live warning

  // Short inputs are treated as already qualified by the analog side
  logic [3:0] scSyncA_reg;   // First stage
  logic [3:0] scSync_reg;    // Second stage

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scSyncA_reg <= 4'h0;
      scSync_reg  <= 4'h0;
    end else begin
      scSyncA_reg <= shortDetect;
      scSync_reg  <= scSyncA_reg;
    end
  end

  // ----------------------------------------------------------------
  // Latched status flags
  // ----------------------------------------------------------------
  logic       otLatch_reg;    // Overtemperature flag
  logic       ovLatch_reg;    // Overvoltage flag
  logic       uvLatch_reg;    // Undervoltage flag
  logic [3:0] scLatch_reg;    // Short flags, SCG1..SCP2

  // Pin-driven release of latches: sleep or disable
  wire pinRelease = !chip_enable_pin || disable_pin;
  // Overtemp flag may only clear once the comparator has cooled
  wire otClearOk  = (faultClear || pinRelease) && !otActive;
  wire anyClear   = faultClear || pinRelease;

  // Set wins over clear for every flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      otLatch_reg <= 1'b0;
      ovLatch_reg <= 1'b0;
      uvLatch_reg <= 1'b0;
      scLatch_reg <= 4'h0;
    end else begin
      if (otActive) begin
        otLatch_reg <= 1'b1;
      end else if (otClearOk) begin
        otLatch_reg <= 1'b0;
      end
      if (ovActive) begin
        ovLatch_reg <= 1'b1;
      end else if (anyClear) begin
        ovLatch_reg <= 1'b0;
      end
      if (uvActive) begin
        uvLatch_reg <= 1'b1;
      end else if (anyClear) begin
        uvLatch_reg <= 1'b0;
      end
      scLatch_reg <= scSync_reg | (anyClear ? 4'h0 : scLatch_reg);
    end
  end

  // ----------------------------------------------------------------
  // Input selection and decode
  // ----------------------------------------------------------------
  wire inOne = inputSelect ? virtual_input_one : direction_input_one;
  wire inTwo = inputSelect ? virtual_input_two : direction_input_two;

  // Full-bridge: 11 -> H/L, 01 -> L/H, x0 -> H/H
  wire fullOneHigh = !inTwo || inOne;
  wire fullTwoHigh = !inTwo || !inOne;
  wire oneHigh     = bridgeMode ? fullOneHigh : inOne;
  wire twoHigh     = bridgeMode ? fullTwoHigh : inTwo;

  // Short on leg one is SCG1 or SCP1, leg two SCG2 or SCP2
  wire scLegOne = scLatch_reg[0] || scLatch_reg[2];
  wire scLegTwo = scLatch_reg[1] || scLatch_reg[3];
  wire scAny    = scLegOne || scLegTwo;

  // Tri-state conditions
  wire pinsRun  = chip_enable_pin && !disable_pin && outputEnable;
  wire offBoth  = !pinsRun || uvActive || otLatch_reg;
  wire offOne   = offBoth || (bridgeMode ? scAny : scLegOne);
  wire offTwo   = offBoth || (bridgeMode ? scAny : scLegTwo);
  // Overvoltage braking in full bridge unless protection disabled
  wire ovBrake  = ovActive && bridgeMode && !ov_protect_disable;

  // Leg commands; offs override braking so tri-state wins
  wire oneHiNext = !offOne && (ovBrake || oneHigh);
  wire oneLoNext = !offOne && !ovBrake && !oneHigh;
  wire twoHiNext = !offTwo && (ovBrake || twoHigh);
  wire twoLoNext = !offTwo && !ovBrake && !twoHigh;

  // ----------------------------------------------------------------
  // Status vector and fault pin
  // ----------------------------------------------------------------
  logic [ST_W-1:0] status_next;   // Assembled status bits

  always_comb begin
    status_next           = '0;
    status_next[ST_OT]    = otLatch_reg;
    status_next[ST_TW]    = twActive;
    status_next[ST_SCG1]  = scLatch_reg[0];
    status_next[ST_SCG2]  = scLatch_reg[1];
    status_next[ST_SCP1]  = scLatch_reg[2];
    status_next[ST_SCP2]  = scLatch_reg[3];
    status_next[ST_OV]    = ovLatch_reg;
    status_next[ST_UV]    = uvLatch_reg;
  end

  // Masked faults pull the pin low while awake; disable also pulls it low but sleep does not
  wire maskedFault   = |(status_next & faultMask);
  wire disabledAwake = chip_enable_pin && (disable_pin || !outputEnable);
  wire faultPinLow   = chip_enable_pin && (maskedFault || disabledAwake);

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      highSideOn     <= 2'h0;
      lowSideOn      <= 2'h0;
      fault_status_n <= 1'b1;
      statusFlags    <= '0;
    end else begin
      highSideOn     <= {twoHiNext, oneHiNext};
      lowSideOn      <= {twoLoNext, oneLoNext};
      fault_status_n <= !faultPinLow;
      statusFlags    <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_no_shoot;
    @(posedge clk) disable iff (sys_rst)
      (highSideOn & lowSideOn) == 2'h0;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("high and low side on together");

  property p_uv_off;
    @(posedge clk) disable iff (sys_rst)
      uvActive |=> (highSideOn == 2'h0) && (lowSideOn == 2'h0);
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("outputs on during undervoltage");

  property p_ot_off;
    @(posedge clk) disable iff (sys_rst)
      otLatch_reg |=> (highSideOn == 2'h0) && (lowSideOn == 2'h0);
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("outputs on with overtemp latched");

  property p_ov_brake;
    @(posedge clk) disable iff (sys_rst)
      (ovActive && bridgeMode && !ov_protect_disable && !offBoth && !scAny)
        |=> (highSideOn == 2'h3);
  endproperty
  a_ov_brake: assert property (p_ov_brake)
    else $error("no high-side braking in overvoltage");

  property p_ov_sticky;
    @(posedge clk) disable iff (sys_rst)
      (ovLatch_reg && !ovActive && !anyClear) |=> ovLatch_reg;
  endproperty
  a_ov_sticky: assert property (p_ov_sticky)
    else $error("overvoltage flag lost without clear");

  property p_half_follow;
    @(posedge clk) disable iff (sys_rst)
      (!bridgeMode && pinsRun && !uvActive && !otLatch_reg && scLatch_reg == 4'h0)
        |=> (highSideOn[0] == $past(inOne)) && (lowSideOn[0] == !$past(inOne));
  endproperty
  a_half_follow: assert property (p_half_follow)
    else $error("half-bridge leg one does not follow input");

  property p_dis_pin;
    @(posedge clk) disable iff (sys_rst)
      (chip_enable_pin && disable_pin) |=> !fault_status_n && (highSideOn == 2'h0);
  endproperty
  a_dis_pin: assert property (p_dis_pin)
    else $error("disable did not tri-state and flag");

  property p_sleep_pin;
    @(posedge clk) disable iff (sys_rst)
      !chip_enable_pin |=> fault_status_n && (lowSideOn == 2'h0);
  endproperty
  a_sleep_pin: assert property (p_sleep_pin)
    else $error("sleep did not tri-state with pin high");

  property p_tw_live;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> statusFlags[ST_TW] == $past(twActive);
  endproperty
  a_tw_live: assert property (p_tw_live)
    else $error("warning flag not live");
endmodule : bridge_fault_supervisor
`default_nettype wire

/* bridge_host_model.sv */
/*
  Host-side model of the bridge fault supervisor: drives the control pins
  and configuration bits, and issues fault clears, from bench-called tasks.
  Assumes one clock; every change is made by non-blocking assignment at a
  rising edge, so the supervisor sees it on the following edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_host_model (
  input  wire logic       clk,
  output logic            chip_enable_pin,
  output logic            disable_pin,
  output logic            direction_input_one,
  output logic            direction_input_two,
  output logic            virtual_input_one,
  output logic            virtual_input_two,
  output logic            inputSelect,
  output logic            outputEnable,
  output logic            bridgeMode,
  output logic            ov_protect_disable,
  output logic [9:0]      faultMask,
  output logic            faultClear
);
  import bridge_fault_pkg::*;

  // ----------------------------------------------------------------
  // Time zero levels and access tasks
  // ----------------------------------------------------------------
  // Asleep and disabled; floating direction inputs are driven low
  initial begin
    chip_enable_pin     = 1'h0;
    disable_pin         = 1'h1;
    direction_input_one = 1'h0;
    direction_input_two = 1'h0;
    virtual_input_one   = 1'h0;
    virtual_input_two   = 1'h0;
    inputSelect         = 1'h0;
    outputEnable        = 1'h1;
    bridgeMode          = 1'h1;
    ov_protect_disable  = 1'h0;
    faultMask           = MASK_RESET;
    faultClear          = 1'h0;
  end

  // Configuration bits, all in one edge
  task automatic setCfg(input logic mode, input logic sel, input logic oe,
                        input logic ovd, input logic [9:0] mask);
    @(posedge clk);
    bridgeMode         <= mode;
    inputSelect        <= sel;
    outputEnable       <= oe;
    ov_protect_disable <= ovd;
    faultMask          <= mask;
  endtask : setCfg

  // Pins; a disable or sleep release also empties the latches
  task automatic setPins(input logic en, input logic dis, input logic d1,
                         input logic d2, input logic v1, input logic v2);
    @(posedge clk);
    chip_enable_pin     <= en;
    disable_pin         <= dis;
    direction_input_one <= d1;
    direction_input_two <= d2;
    virtual_input_one   <= v1;
    virtual_input_two   <= v2;
  endtask : setPins

  // One-cycle clear; the supervisor refuses the overtemp clear while hot
  task automatic pulseClear();
    @(posedge clk);
    faultClear <= 1'h1;
    @(posedge clk);
    faultClear <= 1'h0;
  endtask : pulseClear
endmodule : bridge_host_model
`default_nettype wire

/* bridge_fault_supervisor_tb_top.sv */
/*
  Self-checking bench of the bridge fault supervisor: decode tables,
  tri-state conditions, filtered supply and temperature faults, shorts.
  Assumes the host model for pins and the package filter cycle counts.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_fault_supervisor_tb_top;
  import bridge_fault_pkg::*;
  // ----------------------------------------------------------------
  // Signals, instances and checking helpers
  // ----------------------------------------------------------------
  logic             clk;          // 50 MHz clock
  logic             sys_rst;      // Synchronous reset
  logic             uvComp, ovComp, twComp, otComp;
  logic [3:0]       shortDetect;  // Pre-qualified short levels
  wire              enPin, disPin, dir1, dir2, virt1, virt2, sel, oe, mode, ovd, clr;
  wire  [9:0]       mask;
  logic [1:0]       highSideOn, lowSideOn;
  logic             fault_status_n;
  logic [ST_W-1:0]  statusFlags;
  int               mismatches = 0;
  int               n_compared = 0;

  bridge_host_model host (.clk(clk), .chip_enable_pin(enPin), .disable_pin(disPin),
    .direction_input_one(dir1), .direction_input_two(dir2), .virtual_input_one(virt1),
    .virtual_input_two(virt2), .inputSelect(sel), .outputEnable(oe), .bridgeMode(mode),
    .ov_protect_disable(ovd), .faultMask(mask), .faultClear(clr));

  bridge_fault_supervisor dut (.clk(clk), .sys_rst(sys_rst), .chip_enable_pin(enPin),
    .disable_pin(disPin), .direction_input_one(dir1), .direction_input_two(dir2),
    .virtual_input_one(virt1), .virtual_input_two(virt2), .inputSelect(sel),
    .outputEnable(oe), .bridgeMode(mode), .ov_protect_disable(ovd), .faultMask(mask),
    .faultClear(clr), .uvComp(uvComp), .ovComp(ovComp), .twComp(twComp),
    .otComp(otComp), .shortDetect(shortDetect), .highSideOn(highSideOn),
    .lowSideOn(lowSideOn), .fault_status_n(fault_status_n), .statusFlags(statusFlags));

  // Free-running clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Packs two leg commands and the pin level as {high, low, pin}
  function automatic logic [4:0] expOut(input leg_cmd_t a, input leg_cmd_t b, input logic f);
    return {b == LEG_HIGH, a == LEG_HIGH, b == LEG_LOW, a == LEG_LOW, f};
  endfunction : expOut

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkOut(input string what, input leg_cmd_t a, input leg_cmd_t b, input logic f);
    chk(what, {5'h00, expOut(a, b, f)}, {5'h00, highSideOn, lowSideOn, fault_status_n});
  endtask : chkOut

  // Let n edges pass, then sample once their updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, well above the summed filter waits
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    uvComp = 1'h0;
    ovComp = 1'h0;
    twComp = 1'h0;
    otComp = 1'h0;
    shortDetect = 4'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    wt(1);
    chkOut("reset outputs", LEG_OFF, LEG_OFF, 1'h1);
    chk("reset flags", 10'h000, statusFlags);
    // Half bridge, virtual inputs opposite and ignored
    host.setCfg(1'h0, 1'h0, 1'h1, 1'h0, MASK_RESET);
    for (int i = 0; i < 4; i++) begin
      host.setPins(1'h1, 1'h0, i[0], i[1], ~i[0], ~i[1]);
      wt(3);
      chkOut("half decode", i[0] ? LEG_HIGH : LEG_LOW, i[1] ? LEG_HIGH : LEG_LOW, 1'h1);
    end
    // Full bridge, pins then virtual inputs, the unused source opposite
    for (int i = 0; i < 8; i++) begin
      host.setCfg(1'h1, i[2], 1'h1, 1'h0, MASK_RESET);
      host.setPins(1'h1, 1'h0, i[0] ^ i[2], i[1] ^ i[2], ~(i[0] ^ i[2]), ~(i[1] ^ i[2]));
      wt(3);
      chkOut("full decode", (i[1] & ~i[0]) ? LEG_LOW : LEG_HIGH,
             (i[1] & i[0]) ? LEG_LOW : LEG_HIGH, 1'h1);
    end
    // Tri-state sources; sleep last, since it also empties the latches
    host.setPins(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    wt(3);
    chkOut("disable pin", LEG_OFF, LEG_OFF, 1'h0);
    host.setPins(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    host.setCfg(1'h1, 1'h0, 1'h0, 1'h0, MASK_RESET);
    wt(3);
    chkOut("enable bit", LEG_OFF, LEG_OFF, 1'h0);
    host.setCfg(1'h1, 1'h0, 1'h1, 1'h0, MASK_RESET | 10'h100);
    host.setPins(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    wt(3);
    chkOut("sleep", LEG_OFF, LEG_OFF, 1'h1);
    host.setPins(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    wt(3);
    chkOut("wake reverse", LEG_LOW, LEG_HIGH, 1'h1);
    // Overvoltage with a short dropout that must restart the filter
    @(posedge clk) ovComp <= 1'h1;
    wt(OV_CYCLES - 10);
    @(posedge clk) ovComp <= 1'h0;
    wt(3);
    @(posedge clk) ovComp <= 1'h1;
    wt(OV_CYCLES - 10);
    chk("ov glitch flags", 10'h000, statusFlags);
    wt(30);
    chkOut("ov braking", LEG_HIGH, LEG_HIGH, 1'h0);
    chk("ov flags", 10'h100, statusFlags);
    @(posedge clk) ovComp <= 1'h0;
    wt(OV_CYCLES + 10);
    chkOut("ov recovered", LEG_LOW, LEG_HIGH, 1'h0);
    chk("ov flag kept", 10'h100, statusFlags);
    host.pulseClear();
    wt(3);
    chkOut("ov cleared", LEG_LOW, LEG_HIGH, 1'h1);
    chk("ov flags cleared", 10'h000, statusFlags);
    // Half bridge, then full bridge with protection disabled: no braking
    for (int j = 0; j < 2; j++) begin
      host.setCfg(j[0], 1'h0, 1'h1, j[0], MASK_RESET | 10'h100);
      @(posedge clk) ovComp <= 1'h1;
      wt(OV_CYCLES + 10);
      chkOut("ov no braking", LEG_LOW, LEG_HIGH, 1'h0);
      chk("ov warning flag", 10'h100, statusFlags);
      @(posedge clk) ovComp <= 1'h0;
      wt(OV_CYCLES + 10);
      host.pulseClear();
      wt(3);
    end
    // Undervoltage with the default mask
    host.setCfg(1'h1, 1'h0, 1'h1, 1'h0, MASK_RESET);
    @(posedge clk) uvComp <= 1'h1;
    wt(UV_CYCLES - 2);
    chkOut("uv filtering", LEG_LOW, LEG_HIGH, 1'h1);
    wt(10);
    chkOut("uv lockout", LEG_OFF, LEG_OFF, 1'h0);
    chk("uv flags", 10'h200, statusFlags);
    @(posedge clk) uvComp <= 1'h0;
    wt(UV_CYCLES - 2);
    chkOut("uv recovering", LEG_OFF, LEG_OFF, 1'h0);
    wt(10);
    chkOut("uv recovered", LEG_LOW, LEG_HIGH, 1'h0);
    host.pulseClear();
    wt(3);
    chkOut("uv cleared", LEG_LOW, LEG_HIGH, 1'h1);
    // Temperature warning: flag only, and live
    @(posedge clk) twComp <= 1'h1;
    wt(10);
    chkOut("warning outputs", LEG_LOW, LEG_HIGH, 1'h1);
    chk("warning flag", 10'h002, statusFlags);
    @(posedge clk) twComp <= 1'h0;
    wt(10);
    chk("warning gone", 10'h000, statusFlags);
    // Overtemperature latch, clear refused while hot
    @(posedge clk) otComp <= 1'h1;
    wt(OT_CYCLES + 10);
    chkOut("ot latched", LEG_OFF, LEG_OFF, 1'h0);
    chk("ot flags", 10'h001, statusFlags);
    host.pulseClear();
    wt(3);
    chkOut("ot clear hot", LEG_OFF, LEG_OFF, 1'h0);
    @(posedge clk) otComp <= 1'h0;
    wt(OT_CYCLES + 10);
    chkOut("ot cool latched", LEG_OFF, LEG_OFF, 1'h0);
    host.pulseClear();
    wt(3);
    chkOut("ot released", LEG_LOW, LEG_HIGH, 1'h1);
    // Short in half bridge hits one leg; disable pin release clears it
    host.setCfg(1'h0, 1'h0, 1'h1, 1'h0, MASK_RESET);
    host.setPins(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    @(posedge clk) shortDetect <= 4'h1;
    wt(8);
    chkOut("half short", LEG_OFF, LEG_HIGH, 1'h0);
    chk("short flags", 10'h010, statusFlags);
    @(posedge clk) shortDetect <= 4'h0;
    wt(3); // Synchroniser must drain first, else set beats the release
    host.setPins(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    host.setPins(1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    wt(3);
    chkOut("short pin clear", LEG_HIGH, LEG_HIGH, 1'h1);
    // Short in full bridge hits both legs; serial clear releases
    host.setCfg(1'h1, 1'h0, 1'h1, 1'h0, MASK_RESET);
    @(posedge clk) shortDetect <= 4'h8;
    wt(8);
    chkOut("full short", LEG_OFF, LEG_OFF, 1'h0);
    @(posedge clk) shortDetect <= 4'h0;
    wt(3); // Same drain before the serial clear
    host.pulseClear();
    wt(3);
    chkOut("short cleared", LEG_HIGH, LEG_LOW, 1'h1);
    print_verdict();
  end
endmodule : bridge_fault_supervisor_tb_top
`default_nettype wire
